// ---- src/acd_pkg.sv ----
// What this block does
// RL1 - Host loads parameter registers first; the opcode write starts the command.
// RL2 - Host writes a new opcode only while busy reads zero.
// RL3 - Every supported opcode belongs to one of three acceptance classes.
// RL4 - Opcodes 38h and CDh are write commands; 38h class 2, CDh class 3.
// RL5 - C5h, CDh, 3Ch are class 3; CAh, 30h, 31h are class 2.
// RL6 - B9 uses feature: 80 class 1, 81 class 2, 0-127 structure read.
// RL7 - Only parameter registers valid for the opcode are passed on; others ignored.
// RL8 - Drive-only commands use the drive bit; full-use commands also use the head.
// RL9 - LBA-capable commands take LBA or CHS as the addressing-mode bit selects.
// RL10 - Power-mode check 98h or E5h uses only the drive bit.
// RL11 - Power-mode check: busy, count register to 00h, clear busy, interrupt.
// RL12 - Card never idles; sleep is left within 200 ms.
// RL13 - Opcode 90h runs the self-diagnostic and loads its code into the error register.
// RL14 - Codes: 01 ok, 02 formatter, 03 buffer, 04 correction, 05 processor, 8x slave.
// RL15 - In card mode the diagnostic runs only when the drive bit addresses this card.
// RL16 - In IDE mode the drive bit is ignored; master reports both devices.
// RL17 - Error flag is set whenever the previous command ended in error.
// RL18 - Completion interrupts reach the host only while interrupt_disable is zero.
// RL19 - Unknown opcode ends with error flag, aborted-command error, busy cleared.
// RL20 - Busy holds from opcode write to setup end; opcode writes while busy ignored.
package acd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FEATURE = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SECTOR = 8'h08;
  localparam logic [7:0] OFS_TRACK = 8'h0C;
  localparam logic [7:0] OFS_DRVHEAD = 8'h10;
  localparam logic [7:0] OFS_CMD_STAT = 8'h14;
  localparam logic [7:0] OFS_ERROR = 8'h18;
  localparam logic [7:0] OFS_DEVCTRL = 8'h1C;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  // Field positions
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRIVE_BIT = 4;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_ERR_BIT = 0;
  localparam int DC_IDIS_BIT = 1;
  localparam int DC_SRST_BIT = 2;
  localparam int CF_IDE_BIT = 0;
  localparam int CF_DRIVE_BIT = 1;
  localparam int CF_SLAVE_FAIL_BIT = 2;
  localparam int CF_FAULT_LSB = 4;
  // Opcodes handled here in full; B9 and its feature values are only classified here
  localparam logic [7:0] OP_PWR_A = 8'h98;
  localparam logic [7:0] OP_PWR_B = 8'hE5;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_SLEEP_A = 8'hE6;
  localparam logic [7:0] OP_SLEEP_B = 8'h99;
  localparam logic [7:0] OP_KEY = 8'hB9;
  localparam logic [7:0] KEY_READ_MAT = 8'h80;
  localparam logic [7:0] KEY_CHANGE = 8'h81;
  // Error register values, diagnostic codes and the power-check count value
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_SLAVE = 8'h81;
  localparam logic [7:0] PWR_COUNT = 8'h00;
  // Parameter-use masks: {feature, count, sector, track, head, lba}
  localparam logic [5:0] PU_DRIVE = 6'b00_0000;
  localparam logic [5:0] PU_RW = 6'b01_1111;
  localparam logic [5:0] PU_CNT = 6'b01_0000;
  localparam logic [5:0] PU_CNT_HEAD = 6'b01_0010;
  localparam logic [5:0] PU_FORMAT = 6'b01_0111;
  localparam logic [5:0] PU_ADDR = 6'b00_1111;
  localparam logic [5:0] PU_FEAT = 6'b10_0000;
  localparam logic [5:0] PU_KEY = 6'b11_1110;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DIAG_TIME_NS = 2000;
  localparam int DIAG_CYCLES = DIAG_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_TIME_MS = 200;
  localparam int WAKE_CYCLES_DOC = WAKE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 21;

  typedef enum logic [4:0] {
    ACD_IDLE = 5'b00001,
    ACD_DECODE = 5'b00010,
    ACD_EXEC = 5'b00100,
    ACD_DIAG = 5'b01000,
    ACD_WAKE = 5'b10000
  } acd_state_e;
endpackage

// ---- src/acd_command_decoder.sv ----
`timescale 1ns/100ps
module acd_command_decoder #(
  parameter int WAKE_CYCLES = acd_pkg::WAKE_CYCLES_DOC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command hand-off to the execution engine
  output logic cmd_start,
  output logic [7:0] cmd_opcode,
  output logic [1:0] cmd_class,
  output logic [7:0] cmd_feature,
  output logic [7:0] cmd_count,
  output logic [7:0] cmd_sector,
  output logic [15:0] cmd_track,
  output logic [3:0] cmd_head,
  output logic cmd_drive,
  output logic cmd_lba,
  input wire logic cmd_done,
  input wire logic cmd_fail,
  // Host-facing status
  output logic busy,
  output logic intrq
);
  import acd_pkg::*;

  localparam int DIAG_HI = DIAG_CYCLES + 2;

  acd_state_e st_q;
  logic [7:0] feat_q, count_q, sect_q, dh_q, op_q, err_reg_q, cfg_q;
  logic [15:0] track_q;
  logic busy_q, err_q, pend_q, idis_q, srst_q, sleep_q, pready_q;
  logic [CNT_W-1:0] cnt_q;
  logic [31:0] rdata_d;
  logic acc, wr, rd_stat, cmd_wr, cmd_take, finish, pend_d, idis_d;
  logic [1:0] cls_d;
  logic [5:0] pu_d;
  logic [2:0] fault;
  logic diag_run, is_pwr, is_diag, is_sleep;
  logic [7:0] diag_code;

  // Class and parameter-use table
  function automatic logic [7:0] decode_op(input logic [7:0] op, input logic [7:0] fr);
    logic [1:0] c;
    logic [5:0] p;
    c = 2'd1;
    p = PU_DRIVE;
    casez (op)
      8'hE5, 8'h98, 8'h90, 8'hE7, 8'hEC, 8'hE1, 8'h95, 8'h00, 8'hE4, 8'h03,
      8'hF6, 8'hF3, 8'hF4, 8'hF5, 8'hF1, 8'hF2, 8'hE6, 8'h99, 8'hE2, 8'h96,
      8'hE0, 8'h94, 8'h1?: p = PU_DRIVE;
      8'hE3, 8'h97, 8'hC6: p = PU_CNT;
      8'h91: p = PU_CNT_HEAD;
      8'hEF: p = PU_FEAT;
      8'hC0, 8'hC8, 8'hC4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87: p = PU_RW;
      8'h22, 8'h23, 8'h7?: p = PU_ADDR;
      8'h50: begin
        c = 2'd2;
        p = PU_FORMAT;
      end
      8'hE8: c = 2'd2;
      8'hCA, 8'h30, 8'h31, 8'h38: begin // [RL4] [RL5]
        c = 2'd2;
        p = PU_RW;
      end
      8'h32, 8'h33: begin
        c = 2'd2;
        p = PU_ADDR;
      end
      8'hC5, 8'hCD, 8'h3C: begin // [RL4] [RL5]
        c = 2'd3;
        p = PU_RW;
      end
      OP_KEY: begin // [RL6]
        p = PU_KEY;
        if (fr == KEY_CHANGE) c = 2'd2;
        else if (fr == KEY_READ_MAT || !fr[7]) c = 2'd1;
        else c = 2'd0;
      end
      default: c = 2'd0;
    endcase
    return {c, p};
  endfunction

  assign {cls_d, pu_d} = decode_op(op_q, feat_q); // [RL3]
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd_stat = acc && !pwrite && paddr == OFS_CMD_STAT;
  assign cmd_wr = wr && paddr == OFS_CMD_STAT;
  assign cmd_take = cmd_wr && !busy_q && !srst_q; // [RL20] [RL1]
  assign is_pwr = op_q == OP_PWR_A || op_q == OP_PWR_B;
  assign is_diag = op_q == OP_DIAG;
  assign is_sleep = op_q == OP_SLEEP_A || op_q == OP_SLEEP_B;
  assign fault = cfg_q[CF_FAULT_LSB +: 3];
  // Card mode runs only when addressed; IDE mode ignores the drive bit
  assign diag_run = cfg_q[CF_IDE_BIT] || dh_q[DH_DRIVE_BIT] == cfg_q[CF_DRIVE_BIT]; // [RL15] [RL16]
  always_comb begin
    if (fault >= 3'd2 && fault <= 3'd5) diag_code = {5'h00, fault}; // [RL14]
    else if (cfg_q[CF_IDE_BIT] && !cfg_q[CF_DRIVE_BIT] && cfg_q[CF_SLAVE_FAIL_BIT])
      diag_code = DIAG_SLAVE; // [RL16]
    else diag_code = DIAG_OK;
  end
  assign finish = (st_q == ACD_DECODE && (cls_d == 2'd0 || is_pwr || is_sleep ||
                   (is_diag && !diag_run))) || (st_q == ACD_EXEC && cmd_done) ||
                  (st_q == ACD_DIAG && cnt_q == '0);

  // APB: one wait state, answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      prdata <= (psel && penable && !pready_q && !pwrite) ? rdata_d : 32'h0000_0000;
      pslverr <= psel && penable && !pready_q && paddr > OFS_CONFIG;
    end
  end
  assign pready = pready_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      OFS_FEATURE: rdata_d[7:0] = feat_q;
      OFS_COUNT: rdata_d[7:0] = count_q;
      OFS_SECTOR: rdata_d[7:0] = sect_q;
      OFS_TRACK: rdata_d[15:0] = track_q;
      OFS_DRVHEAD: rdata_d[7:0] = dh_q;
      OFS_CMD_STAT: begin
        rdata_d[ST_BUSY_BIT] = busy_q || srst_q;
        rdata_d[ST_READY_BIT] = !busy_q && !srst_q;
        rdata_d[ST_DSC_BIT] = !busy_q && !srst_q;
        rdata_d[ST_ERR_BIT] = err_q; // [RL17]
      end
      OFS_ERROR: rdata_d[7:0] = err_reg_q;
      OFS_DEVCTRL: begin
        rdata_d[DC_IDIS_BIT] = idis_q;
        rdata_d[DC_SRST_BIT] = srst_q;
      end
      OFS_CONFIG: rdata_d[7:0] = cfg_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Parameter registers; the power check overwrites the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_q <= 8'h00;
      count_q <= 8'h00;
      sect_q <= 8'h00;
      track_q <= 16'h0000;
      dh_q <= 8'h00;
      cfg_q <= 8'h00;
    end else begin
      if (st_q == ACD_DECODE && is_pwr) count_q <= PWR_COUNT; // [RL11]
      else if (wr && paddr == OFS_COUNT && !busy_q) count_q <= pwdata[7:0];
      if (wr && !busy_q) begin
        if (paddr == OFS_FEATURE) feat_q <= pwdata[7:0];
        if (paddr == OFS_SECTOR) sect_q <= pwdata[7:0];
        if (paddr == OFS_TRACK) track_q <= pwdata[15:0];
        if (paddr == OFS_DRVHEAD) dh_q <= pwdata[7:0];
        if (paddr == OFS_CONFIG) cfg_q <= pwdata[7:0];
      end
    end
  end

  // Device control is writable even while busy
  assign idis_d = (wr && paddr == OFS_DEVCTRL) ? pwdata[DC_IDIS_BIT] : idis_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idis_q <= 1'b0; // [RL18]
      srst_q <= 1'b0;
    end else if (wr && paddr == OFS_DEVCTRL) begin
      idis_q <= pwdata[DC_IDIS_BIT];
      srst_q <= pwdata[DC_SRST_BIT];
    end
  end

  // Command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ACD_IDLE;
      busy_q <= 1'b0;
      op_q <= 8'h00;
      cnt_q <= '0;
      sleep_q <= 1'b0;
    end else if (srst_q) begin
      st_q <= ACD_IDLE;
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      unique case (st_q)
        ACD_IDLE: if (cmd_take) begin
          busy_q <= 1'b1; // [RL20]
          op_q <= pwdata[7:0];
          // Leaving sleep costs the wake-up time, never an idle state
          if (sleep_q) begin // [RL12]
            st_q <= ACD_WAKE;
            cnt_q <= CNT_W'(WAKE_CYCLES - 1);
          end else st_q <= ACD_DECODE;
        end
        ACD_WAKE: begin
          sleep_q <= 1'b0;
          if (cnt_q == '0) st_q <= ACD_DECODE;
          else cnt_q <= cnt_q - 1'b1;
        end
        ACD_DECODE: begin
          if (is_sleep && cls_d != 2'd0) sleep_q <= 1'b1;
          if (finish) begin
            busy_q <= 1'b0; // [RL11] [RL19]
            st_q <= ACD_IDLE;
          end else if (is_diag) begin // [RL13]
            st_q <= ACD_DIAG;
            cnt_q <= CNT_W'(DIAG_CYCLES - 1);
          end else st_q <= ACD_EXEC;
        end
        ACD_EXEC: if (cmd_done) begin
          busy_q <= 1'b0;
          st_q <= ACD_IDLE;
        end
        ACD_DIAG: if (cnt_q == '0) begin
          busy_q <= 1'b0;
          st_q <= ACD_IDLE;
        end else cnt_q <= cnt_q - 1'b1;
        default: st_q <= ACD_IDLE;
      endcase
    end
  end
  assign busy = busy_q;

  // Error flag and error register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
      err_reg_q <= 8'h00;
    end else if (srst_q || cmd_take) begin
      err_q <= 1'b0;
      err_reg_q <= 8'h00;
    end else if (st_q == ACD_DECODE && cls_d == 2'd0) begin
      err_q <= 1'b1; // [RL19] [RL17]
      err_reg_q <= ERR_ABORT;
    end else if (st_q == ACD_EXEC && cmd_done && cmd_fail) begin
      err_q <= 1'b1; // [RL17]
      err_reg_q <= ERR_ABORT;
    end else if (st_q == ACD_DIAG && cnt_q == '0) begin
      err_reg_q <= diag_code; // [RL13] [RL14]
      err_q <= diag_code != DIAG_OK;
    end
  end

  // Pending completion; a new completion wins over a status-read clear
  assign pend_d = (finish && !(st_q == ACD_DECODE && is_diag && !diag_run)) ||
                  (pend_q && !rd_stat && !cmd_take && !srst_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      intrq <= 1'b0;
    end else begin
      pend_q <= pend_d;
      intrq <= pend_d && !idis_d; // [RL18]
    end
  end

  // Hand-off of masked parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_start <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_class <= 2'd0;
      cmd_feature <= 8'h00;
      cmd_count <= 8'h00;
      cmd_sector <= 8'h00;
      cmd_track <= 16'h0000;
      cmd_head <= 4'h0;
      cmd_drive <= 1'b0;
      cmd_lba <= 1'b0;
    end else begin
      cmd_start <= st_q == ACD_DECODE && !finish && !is_diag && !srst_q;
      if (st_q == ACD_DECODE) begin
        cmd_opcode <= op_q;
        cmd_class <= cls_d; // [RL3]
        cmd_feature <= pu_d[5] ? feat_q : 8'h00; // [RL7]
        cmd_count <= pu_d[4] ? count_q : 8'h00; // [RL7]
        cmd_sector <= pu_d[3] ? sect_q : 8'h00;
        cmd_track <= pu_d[2] ? track_q : 16'h0000;
        cmd_head <= pu_d[1] ? dh_q[3:0] : 4'h0; // [RL8] [RL10]
        cmd_drive <= dh_q[DH_DRIVE_BIT]; // [RL8]
        cmd_lba <= pu_d[0] && dh_q[DH_LBA_BIT]; // [RL9]
      end
    end
  end

  property p_busy_on_cmd;
    @(posedge pclk) disable iff (!presetn)
      cmd_take |=> busy_q && (st_q == ACD_DECODE || st_q == ACD_WAKE);
  endproperty
  a_busy_on_cmd: assert property (p_busy_on_cmd) else $error("busy not held"); // [RL20]
  property p_ignore_busy;
    @(posedge pclk) disable iff (!presetn) cmd_wr && busy_q |=> $stable(op_q);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("opcode taken while busy"); // [RL20]
  property p_pwr;
    @(posedge pclk) disable iff (!presetn)
      st_q == ACD_DECODE && is_pwr && !srst_q |=> count_q == 8'h00 && !busy_q && pend_q;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power check sequence wrong"); // [RL11]
  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      st_q == ACD_DECODE && cls_d == 2'd0 && !srst_q |=> err_q && err_reg_q == 8'h04 && !busy_q;
  endproperty
  a_abort: assert property (p_abort) else $error("unknown opcode not aborted"); // [RL19]
  property p_class2;
    @(posedge pclk) disable iff (!presetn)
      cmd_start && (cmd_opcode == 8'h38 || cmd_opcode == 8'hCA) |-> cmd_class == 2'd2;
  endproperty
  a_class2: assert property (p_class2) else $error("class 2 write wrong"); // [RL4]
  property p_class3;
    @(posedge pclk) disable iff (!presetn) cmd_start &&
      (cmd_opcode == 8'hC5 || cmd_opcode == 8'hCD || cmd_opcode == 8'h3C) |-> cmd_class == 2'd3;
  endproperty
  a_class3: assert property (p_class3) else $error("class 3 write wrong"); // [RL5]
  property p_key;
    @(posedge pclk) disable iff (!presetn) cmd_start && cmd_opcode == 8'hB9 |->
      cmd_class == (cmd_feature == 8'h81 ? 2'd2 : 2'd1);
  endproperty
  a_key: assert property (p_key) else $error("key class wrong"); // [RL6]
  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      cmd_start && (cmd_opcode == 8'hEC || cmd_opcode == 8'hE7) |->
      cmd_head == 4'h0 && cmd_count == 8'h00 && !cmd_lba;
  endproperty
  a_mask: assert property (p_mask) else $error("unused parameter passed"); // [RL7]
  property p_idis;
    @(posedge pclk) disable iff (!presetn) idis_q |-> !intrq;
  endproperty
  a_idis: assert property (p_idis) else $error("interrupt while disabled"); // [RL18]
  property p_diag;
    @(posedge pclk) disable iff (!presetn || srst_q)
      $rose(st_q == ACD_DIAG) |-> ##[1:DIAG_HI] (!busy_q && err_reg_q != 8'h00);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic result missing"); // [RL13]
  c_pwr: cover property (@(posedge pclk) disable iff (!presetn) st_q == ACD_DECODE && is_pwr);
  c_diag: cover property (@(posedge pclk) disable iff (!presetn) $fell(st_q == ACD_DIAG));
  c_exec: cover property (@(posedge pclk) disable iff (!presetn) cmd_start ##[1:20] cmd_done);
endmodule

// ---- sim/acd_engine_model.sv ----
`timescale 1ns/100ps
module acd_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command hand-off
  input wire logic cmd_start,
  output logic cmd_done,
  output logic cmd_fail,
  // Test controls
  input wire logic [7:0] hold_cycles,
  input wire logic fail_en,
  output logic [7:0] start_count
);
  logic [7:0] wait_q;
  logic run_q;
  // Fail toggles outside done so a decoder that samples it late is caught
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      wait_q <= 8'h00;
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
      start_count <= 8'h00;
    end else begin
      cmd_done <= 1'b0;
      cmd_fail <= ~cmd_fail;
      if (cmd_start) begin
        run_q <= 1'b1;
        wait_q <= hold_cycles;
        start_count <= start_count + 8'h01;
      end else if (run_q) begin
        if (wait_q == 8'h00) begin
          run_q <= 1'b0;
          cmd_done <= 1'b1;
          cmd_fail <= fail_en;
        end else begin
          wait_q <= wait_q - 8'h01;
        end
      end
    end
  end
endmodule

// ---- sim/ata_command_decoder_test.sv ----
`timescale 1ns/100ps
module ata_command_decoder_test;
  import acd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_start, cmd_done, cmd_fail;
  logic [7:0] paddr, cmd_opcode, cmd_feature, cmd_count, cmd_sector, hold_cycles, start_count;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] cmd_class;
  logic [15:0] cmd_track;
  logic [3:0] cmd_head;
  logic cmd_drive, cmd_lba, busy, intrq, fail_en;
  int fail_count = 0;
  int samples_checked = 0;

  acd_command_decoder #(.WAKE_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_start(cmd_start), .cmd_opcode(cmd_opcode),
    .cmd_class(cmd_class), .cmd_feature(cmd_feature), .cmd_count(cmd_count),
    .cmd_sector(cmd_sector), .cmd_track(cmd_track), .cmd_head(cmd_head), .cmd_drive(cmd_drive),
    .cmd_lba(cmd_lba), .cmd_done(cmd_done), .cmd_fail(cmd_fail), .busy(busy), .intrq(intrq));
  acd_engine_model eng (.pclk(pclk), .presetn(presetn), .cmd_start(cmd_start),
    .cmd_done(cmd_done), .cmd_fail(cmd_fail), .hold_cycles(hold_cycles), .fail_en(fail_en),
    .start_count(start_count));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel is never set twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask

  // Busy is polled for up to lim cycles, not checked for an exact length, since only its end is of interest
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n == lim) chk("busy_end", 0, 1);
  endtask

  task automatic ack(input logic [31:0] st);
    rd(OFS_CMD_STAT, r);
    chk("status", st, r & 32'h0000_0081);
    @(posedge pclk);
    chk("intrq_clr", 0, intrq);
  endtask

  task automatic load();
    wr(OFS_COUNT, 32'h0000_0012);
    wr(OFS_SECTOR, 32'h0000_0034);
    wr(OFS_TRACK, 32'h0000_BEEF);
    wr(OFS_DRVHEAD, 32'h0000_0055);
  endtask

  task automatic t_power();
    logic [7:0] ops [3];
    ops = '{OP_PWR_A, OP_PWR_B, OP_PWR_A};
    for (int i = 0; i < 3; i++) begin
      load();
      if (i == 2) begin
        wr(OFS_CMD_STAT, OP_SLEEP_A);
        wait_idle(10);
        ack(32'h0000_0000);
      end
      wr(OFS_CMD_STAT, ops[i]);
      wait_idle(30);
      chk("pwr_irq", 1, intrq);
      rd(OFS_COUNT, r);
      chk("pwr_count", PWR_COUNT, r);
      ack(32'h0000_0000);
    end
    wr(OFS_DEVCTRL, 32'h0000_0002);
    wr(OFS_CMD_STAT, OP_PWR_A);
    wait_idle(10);
    chk("irq_masked", 0, intrq);
    wr(OFS_DEVCTRL, 32'h0000_0000);
    chk("irq_unmasked", 1, intrq);
    ack(32'h0000_0000);
    $display("test power done");
  endtask

  task automatic t_classes();
    logic [7:0] op [11] = '{8'h38, 8'hCD, 8'hC5, 8'h3C, 8'hCA, 8'h30, 8'h31, 8'hE7,
                            OP_KEY, OP_KEY, OP_KEY};
    logic [7:0] ft [11] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A,
                            KEY_READ_MAT, KEY_CHANGE, 8'h10};
    logic [1:0] cl [11] = '{2, 3, 3, 3, 2, 2, 2, 1, 1, 2, 1};
    logic [7:0] s0;
    logic full, key;
    for (int i = 0; i < 11; i++) begin
      full = (i < 7);
      key = (i > 7);
      hold_cycles <= 8'd3;
      wr(OFS_FEATURE, ft[i]);
      load();
      s0 = start_count;
      wr(OFS_CMD_STAT, op[i]);
      wait_idle(20);
      chk("starts", s0 + 8'd1, start_count);
      chk("fields", (full | key) ? {key ? ft[i] : 8'h00, 24'h12_BEEF} : 0,
          {cmd_feature, cmd_count, cmd_track});
      chk("decode", {8'h00, op[i], (full | key) ? 8'h34 : 8'h00, cl[i],
          (full | key) ? 4'h5 : 4'h0, 1'b1, full},
          {8'h00, cmd_opcode, cmd_sector, cmd_class, cmd_head, cmd_drive, cmd_lba});
      chk("cls_irq", 1, intrq);
      ack(32'h0000_0000);
    end
    $display("test classes done");
  endtask

  task automatic t_refuse();
    logic [7:0] s0;
    hold_cycles <= 8'd30;
    fail_en <= 1'b1;
    load();
    s0 = start_count;
    wr(OFS_CMD_STAT, 8'h38);
    wr(OFS_CMD_STAT, 8'hCA);
    wr(OFS_COUNT, 32'h0000_0077);
    wait_idle(60);
    chk("busy_starts", s0 + 8'd1, start_count);
    chk("busy_op", 8'h38, cmd_opcode);
    rd(OFS_COUNT, r);
    chk("busy_count", 32'h0000_0012, r);
    ack(32'h0000_0001);
    fail_en <= 1'b0;
    s0 = start_count;
    wr(OFS_CMD_STAT, 8'hFF);
    wait_idle(10);
    chk("unk_starts", s0, start_count);
    rd(OFS_ERROR, r);
    chk("unk_error", ERR_ABORT, r);
    rd(OFS_COUNT, r);
    chk("unk_count", 32'h0000_0012, r);
    ack(32'h0000_0001);
    // Soft reset clears the error and refuses opcodes until released
    wr(OFS_DEVCTRL, 32'h0000_0004);
    rd(OFS_CMD_STAT, r);
    chk("srst_status", 32'h0000_0080, r & 32'h0000_0081);
    rd(OFS_ERROR, r);
    chk("srst_error", 0, r);
    wr(OFS_CMD_STAT, OP_PWR_A);
    wr(OFS_DEVCTRL, 32'h0000_0000);
    rd(OFS_CMD_STAT, r);
    chk("srst_end", 0, r & 32'h0000_0081);
    rd(OFS_COUNT, r);
    chk("srst_count", 32'h0000_0012, r);
    $display("test refuse done");
  endtask

  task automatic t_diag();
    logic [7:0] cf [7] = '{8'h00, 8'h20, 8'h30, 8'h40, 8'h50, 8'h05, 8'h00};
    logic [7:0] dh [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10};
    logic [7:0] cd [7] = '{DIAG_OK, 8'h02, 8'h03, 8'h04, 8'h05, DIAG_SLAVE, 8'h00};
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CONFIG, cf[i]);
      wr(OFS_DRVHEAD, dh[i]);
      wr(OFS_CMD_STAT, OP_DIAG);
      if (i == 6) begin
        wait_idle(4);
        chk("diag_skip", 0, intrq);
      end else begin
        wait_idle(40);
        rd(OFS_ERROR, r);
        chk("diag_code", cd[i], r);
        ack(cd[i] != DIAG_OK);
      end
    end
    wr(OFS_CONFIG, 32'h0000_0000);
    $display("test diag done");
  endtask

  task automatic t_misc();
    logic e;
    rd(OFS_CMD_STAT, r);
    chk("rst_status", 0, r & 32'h0000_0081);
    chk("rst_irq", 0, intrq);
    apb(1'b0, 8'h24, 32'h0000_0000, r, e);
    chk("unmapped", 32'h0000_0001, {r[30:0], e});
    $display("test misc done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #3000000;
    fail_count++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hold_cycles = 8'd3;
    fail_en = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_misc();
    t_power();
    t_classes();
    t_refuse();
    t_diag();
    conclude();
  end
endmodule
